// ---- rtl/aab_ctrl.sv ----
// accumulator, burst and power-up control of the converter, with its registers
//
// Behaviour
// [RULE1] bit 7 of accumulator config enables twelve-bit conversions.
// [RULE2] burst off, accumulate off: result pair holds only latest conversion.
// [RULE3] burst off, accumulate on: each new result adds into the pair.
// [RULE4] software clears accumulation by writing zero to both result bytes.
// [RULE5] accumulate enable bit 6 is write-only and reads as zero.
// [RULE6] shift/justify codes 000..011 right-justify, shifted right 0..3 bits.
// [RULE7] code 100 left-justifies without shift; codes above are reserved.
// [RULE8] burst repeat codes give 1,4,8,16,32,64 conversions accumulated.
// [RULE9] software keeps repeat count zero while burst mode is off.
// [RULE10] bit 7 of power-up config enables converter low-power mode.
// [RULE11] power-up config bits 6:4 read zero, writes ignored.
// [RULE12] burst off: converter power follows converter enable only.
// [RULE13] burst on, enable set: stay powered, start at once.
// [RULE14] burst on, enable clear: power down after burst, wait before converting.
// [RULE15] power-up delay is field plus one times 400 ns.
// [RULE16] software should program power-up field to four for 2 us tracking.
// [RULE17] done flag after one conversion, or after whole burst.
// [RULE18] result pair is a 16-bit accumulator, formatted reads, direct writes.
// [RULE19] first burst conversion gets no track delay; power-up covers it.
// [RULE20] power-up delay is timed from fixed-rate clock, 400 ns units.
`timescale 1ns/1ps
module aab_ctrl (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire aab_pkg::aab_sfr_req_type sfr,
    output logic [7:0]                    sfr_rdata,
    input  wire logic                     burst_mode_en,
    input  wire logic                     converter_en,
    input  wire logic                     soc,
    input  wire aab_pkg::aab_sar_res_type sar,
    output logic                          sar_start,
    output logic                          first_conv,
    output logic                          conversion_done_set,
    output logic                          converter_power_on,
    output logic                          twelve_bit_mode_en,
    output logic                          low_power_mode_en
);
    import aab_pkg::*;

    aab_state_type s_q;
    aab_state_type s_d;
    logic          tmr_start;
    logic          tmr_expired;
    logic [15:0]   fmt;
    logic [15:0]   sample;
    logic [5:0]    burst_len;
    logic          wr_cfg;
    logic          wr_pwr;
    logic          wr_hi;
    logic          wr_lo;

    // address decode: same offset on two pages selects two registers
    assign wr_cfg = sfr.wr && sfr.addr == ACC_CFG_ADDR && sfr.page == PAGE_MAIN;
    assign wr_pwr = sfr.wr && sfr.addr == PWR_CFG_ADDR && sfr.page == PAGE_CFG;
    assign wr_hi  = sfr.wr && sfr.addr == RES_HI_ADDR && sfr.page == PAGE_MAIN;
    assign wr_lo  = sfr.wr && sfr.addr == RES_LO_ADDR && sfr.page == PAGE_MAIN;

    // new sample, zero-extended from the active resolution
    assign sample = s_q.twelve_bit_mode_en ? {4'h0, sar.data} : {6'h00, sar.data[9:0]};

    // conversions per burst, minus one; reserved codes behave as the longest burst
    always_comb begin
        unique case (s_q.repeat_count)
            RPT_1:   burst_len = 6'd0; // RULE8
            RPT_4:   burst_len = 6'd3;
            RPT_8:   burst_len = 6'd7;
            RPT_16:  burst_len = 6'd15;
            RPT_32:  burst_len = 6'd31;
            default: burst_len = 6'd63;
        endcase
    end

    // power-up wait only for a burst start with the converter disabled
    assign tmr_start = s_q.seq == SEQ_IDLE && soc && burst_mode_en && !converter_en; // RULE14

    aab_pwr_timer u_timer (
        .clk     (clk),
        .rst     (rst),
        .start   (tmr_start),
        .units   (s_q.powerup_time),
        .expired (tmr_expired)
    );

    aab_result_fmt u_fmt (
        .acc    (s_q.acc),
        .sel    (s_q.shift_justify_sel),
        .twelve (s_q.twelve_bit_mode_en),
        .fmt    (fmt)
    );

    // next-state: registers, sequencer, accumulator and read data
    always_comb begin
        s_d = s_q;
        s_d.sar_start = 1'b0;
        s_d.done_set = 1'b0;
        // configuration writes
        if (wr_cfg) begin
            s_d.twelve_bit_mode_en = sfr.wdata[TWELVE_BIT]; // RULE1
            s_d.accumulate_en = sfr.wdata[ACC_EN_BIT];
            s_d.shift_justify_sel = sfr.wdata[SJ_LSB +: 3];
            s_d.repeat_count = sfr.wdata[RPT_LSB +: 3];
        end
        if (wr_pwr) begin
            s_d.low_power_mode_en = sfr.wdata[LPM_BIT]; // RULE10
            s_d.powerup_time = sfr.wdata[PWR_LSB +: 4]; // RULE11
        end
        // conversion sequencer
        unique case (s_q.seq)
            SEQ_IDLE: begin
                if (soc && (converter_en || burst_mode_en)) begin
                    s_d.first_conv = 1'b1; // RULE19
                    s_d.conv_left = burst_mode_en ? burst_len : 6'd0;
                    if (tmr_start) begin
                        s_d.seq = SEQ_POWERUP; // RULE14
                    end else begin
                        s_d.seq = SEQ_CONVERT; // RULE13
                        s_d.sar_start = 1'b1;
                    end
                end
            end
            SEQ_POWERUP: begin
                if (tmr_expired) begin
                    s_d.seq = SEQ_CONVERT; // RULE15
                    s_d.sar_start = 1'b1;
                end
            end
            SEQ_CONVERT: begin
                if (sar.done) begin
                    if (burst_mode_en) begin
                        s_d.acc = s_q.first_conv ? sample : s_q.acc + sample; // RULE8
                    end else if (s_q.accumulate_en) begin
                        s_d.acc = s_q.acc + sample; // RULE3
                    end else begin
                        s_d.acc = sample; // RULE2
                    end
                    if (s_q.conv_left == 6'd0) begin
                        s_d.seq = SEQ_IDLE;
                        s_d.done_set = 1'b1; // RULE17
                    end else begin
                        s_d.conv_left = s_q.conv_left - 6'd1;
                        s_d.sar_start = 1'b1;
                        s_d.first_conv = 1'b0; // RULE19
                    end
                end
            end
        endcase
        // direct byte writes win over a sample landing in the same cycle
        if (wr_hi) begin
            s_d.acc[15:8] = sfr.wdata; // RULE4 RULE18
        end
        if (wr_lo) begin
            s_d.acc[7:0] = sfr.wdata; // RULE4 RULE18
        end
        // power follows enable alone unless a burst owns the converter
        if (burst_mode_en) begin
            s_d.power_on = converter_en || s_d.seq != SEQ_IDLE; // RULE13 RULE14
        end else begin
            s_d.power_on = converter_en; // RULE12
        end
        // read data, registered; unmapped addresses read zero
        s_d.rdata = 8'h00;
        if (sfr.rd) begin
            if (sfr.addr == ACC_CFG_ADDR && sfr.page == PAGE_MAIN) begin
                s_d.rdata = {s_q.twelve_bit_mode_en, 1'b0, s_q.shift_justify_sel,
                             s_q.repeat_count}; // RULE5
            end else if (sfr.addr == PWR_CFG_ADDR && sfr.page == PAGE_CFG) begin
                s_d.rdata = {s_q.low_power_mode_en, 3'h0, s_q.powerup_time}; // RULE11
            end else if (sfr.addr == RES_HI_ADDR && sfr.page == PAGE_MAIN) begin
                s_d.rdata = fmt[15:8]; // RULE18
            end else if (sfr.addr == RES_LO_ADDR && sfr.page == PAGE_MAIN) begin
                s_d.rdata = fmt[7:0]; // RULE18
            end
        end
    end

    // state register; power-up field resets to its longest delay
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.seq <= SEQ_IDLE;
            s_q.twelve_bit_mode_en <= ACC_CFG_RESET[TWELVE_BIT];
            s_q.accumulate_en <= ACC_CFG_RESET[ACC_EN_BIT];
            s_q.shift_justify_sel <= ACC_CFG_RESET[SJ_LSB +: 3];
            s_q.repeat_count <= ACC_CFG_RESET[RPT_LSB +: 3];
            s_q.low_power_mode_en <= PWR_CFG_RESET[LPM_BIT];
            s_q.powerup_time <= PWR_CFG_RESET[PWR_LSB +: 4];
            s_q.acc <= ACC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state
    assign sfr_rdata = s_q.rdata;
    assign sar_start = s_q.sar_start;
    assign first_conv = s_q.first_conv;
    assign conversion_done_set = s_q.done_set;
    assign converter_power_on = s_q.power_on;
    assign twelve_bit_mode_en = s_q.twelve_bit_mode_en;
    assign low_power_mode_en = s_q.low_power_mode_en;

    // helper: cycles spent waiting since a power-up wait began
    logic [7:0] wait_cnt_q;
    logic [7:0] wait_expect;
    always_ff @(posedge clk) begin
        if (rst || tmr_start) begin
            wait_cnt_q <= 8'h00;
        end else if (wait_cnt_q != 8'hFF) begin
            wait_cnt_q <= wait_cnt_q + 8'h01;
        end
    end
    assign wait_expect = 8'((s_q.powerup_time + 1) * PWR_UNIT_CYC);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence burst_cold_start;
        s_q.seq == SEQ_IDLE && soc && burst_mode_en && !converter_en;
    endsequence

    sequence burst_warm_start;
        s_q.seq == SEQ_IDLE && soc && burst_mode_en && converter_en;
    endsequence

    twelve_bit_write_a: assert property (wr_cfg |=> twelve_bit_mode_en == $past(sfr.wdata[7])) // RULE1
        else $error("twelve-bit enable not taken from write");
    acc_en_reads_zero_a: assert property (sfr.rd && sfr.addr == ACC_CFG_ADDR
        && sfr.page == PAGE_MAIN |=> sfr_rdata[ACC_EN_BIT] == 1'b0) // RULE5
        else $error("accumulate enable visible on read");
    unused_bits_zero_a: assert property (sfr.rd && sfr.addr == PWR_CFG_ADDR
        && sfr.page == PAGE_CFG |=> sfr_rdata[6:4] == 3'h0) // RULE11
        else $error("unused power bits not zero");
    power_follows_en_a: assert property (!burst_mode_en |=> converter_power_on
        == $past(converter_en)) // RULE12
        else $error("power not following converter enable");
    warm_start_now_a: assert property (burst_warm_start |=> sar_start && converter_power_on) // RULE13
        else $error("warm burst did not start at once");
    cold_wait_a: assert property (burst_cold_start |=> !sar_start [*8]) // RULE14
        else $error("cold burst started without power-up wait");
    powerup_length_a: assert property (sar_start && $past(s_q.seq) == SEQ_POWERUP
        |-> wait_cnt_q == wait_expect + 8'h01) // RULE15
        else $error("power-up delay length wrong");
    cold_power_down_a: assert property (s_q.seq == SEQ_IDLE && burst_mode_en && !converter_en
        && !soc |=> !converter_power_on) // RULE14
        else $error("converter left powered after burst");
    replace_result_a: assert property (s_q.seq == SEQ_CONVERT && sar.done && !burst_mode_en
        && !s_q.accumulate_en && !wr_hi && !wr_lo |=> s_q.acc == $past(sample)) // RULE2
        else $error("result not replaced");
    add_result_a: assert property (s_q.seq == SEQ_CONVERT && sar.done && !burst_mode_en
        && s_q.accumulate_en && !wr_hi && !wr_lo
        |=> s_q.acc == 16'($past(s_q.acc) + $past(sample))) // RULE3
        else $error("result not accumulated");
    done_at_end_a: assert property (conversion_done_set |-> $past(s_q.conv_left) == 6'd0
        && $past(s_q.seq) == SEQ_CONVERT) // RULE17
        else $error("done flagged before burst end");

    // a start with bursts on, and the first sample of a burst landing
    sequence burst_start_any;
        s_q.seq == SEQ_IDLE && soc && burst_mode_en;
    endsequence

    sequence burst_first_sample;
        s_q.seq == SEQ_CONVERT && sar.done && burst_mode_en && s_q.first_conv
            && !wr_hi && !wr_lo;
    endsequence

    // power configuration fields land one cycle after their write
    lpm_write_a: assert property (wr_pwr // RULE10
        |=> low_power_mode_en == $past(sfr.wdata[LPM_BIT]))
        else $error("low-power enable not taken from write");
    pwr_field_write_a: assert property (wr_pwr // RULE15
        |=> s_q.powerup_time == $past(sfr.wdata[PWR_LSB +: 4]))
        else $error("power-up field not taken from write");

    // direct byte writes reach the accumulator, even over a landing sample
    hi_byte_write_a: assert property (wr_hi // RULE18
        |=> s_q.acc[15:8] == $past(sfr.wdata))
        else $error("high result byte not written");
    lo_byte_write_a: assert property (wr_lo // RULE4
        |=> s_q.acc[7:0] == $past(sfr.wdata))
        else $error("low result byte not written");

    // burst length from the repeat code; reserved codes saturate at 63 left
    burst_length_a: assert property (burst_start_any |=> s_q.conv_left // RULE8
        == (($past(s_q.repeat_count) == RPT_1) ? 6'h00
        : 6'((2 << $past(s_q.repeat_count)) - 1)))
        else $error("burst length not taken from repeat code");
    burst_first_load_a: assert property (burst_first_sample // RULE8
        |=> s_q.acc == $past(sample))
        else $error("first burst sample not loaded");

    // first conversion of a start runs without track delay, later ones with it
    first_conv_set_a: assert property (s_q.seq == SEQ_IDLE && soc // RULE19
        && (converter_en || burst_mode_en) |=> first_conv)
        else $error("first conversion not marked");
    first_conv_clear_a: assert property (s_q.seq == SEQ_CONVERT && sar.done // RULE19
        && s_q.conv_left != 6'h00 |=> !first_conv)
        else $error("later conversion marked as first");

    // power stays up while enabled, and through a cold burst's wait
    warm_power_a: assert property (burst_mode_en && converter_en |=> converter_power_on) // RULE13
        else $error("converter powered down while enabled");
    wait_power_a: assert property (s_q.seq == SEQ_POWERUP && burst_mode_en // RULE14
        |=> converter_power_on)
        else $error("converter off during power-up wait");
    cold_power_up_a: assert property (burst_cold_start // RULE14
        |=> converter_power_on && first_conv)
        else $error("cold burst did not power up");
endmodule // aab_ctrl

// ---- rtl/aab_pkg.sv ----
// package: register map, field layout, timing and types of the accumulator/power block
package aab_pkg;
    // special-function register addresses and pages
    localparam logic [7:0] ACC_CFG_ADDR  = 8'hBA;
    localparam logic [7:0] PWR_CFG_ADDR  = 8'hBA;
    localparam logic [7:0] RES_HI_ADDR   = 8'hBE;
    localparam logic [7:0] RES_LO_ADDR   = 8'hBD;
    localparam logic [7:0] PAGE_MAIN     = 8'h00;
    localparam logic [7:0] PAGE_CFG      = 8'h0F;
    // reset values
    localparam logic [7:0] ACC_CFG_RESET = 8'h00;
    localparam logic [7:0] PWR_CFG_RESET = 8'h0F;
    localparam logic [15:0] ACC_RESET    = 16'h0000;
    // field positions
    localparam int TWELVE_BIT = 7;
    localparam int ACC_EN_BIT = 6;
    localparam int SJ_LSB     = 3;
    localparam int RPT_LSB    = 0;
    localparam int LPM_BIT    = 7;
    localparam int PWR_LSB    = 0;
    // shift/justify codes and left-justify distances
    localparam logic [2:0] SJ_LEFT       = 3'h4;
    localparam logic [3:0] LEFT_SHIFT_12 = 4'h4;
    localparam logic [3:0] LEFT_SHIFT_10 = 4'h6;
    // repeat-count codes
    localparam logic [2:0] RPT_1  = 3'h0;
    localparam logic [2:0] RPT_4  = 3'h1;
    localparam logic [2:0] RPT_8  = 3'h2;
    localparam logic [2:0] RPT_16 = 3'h3;
    localparam logic [2:0] RPT_32 = 3'h4;
    // timing: one power-up unit, rounded up to whole clock cycles
    localparam int CLK_PERIOD_NS = 40;
    localparam int PWR_UNIT_NS   = 400;
    localparam int PWR_UNIT_CYC  = (PWR_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PWR_RELOAD = 4'(PWR_UNIT_CYC - 1);

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] page;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } aab_sfr_req_type;

    typedef struct packed {
        logic        done;
        logic [11:0] data;
    } aab_sar_res_type;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_POWERUP, SEQ_CONVERT} aab_seq_type;

    typedef struct packed {
        logic       busy;
        logic [3:0] prescale;
        logic [3:0] units_left;
        logic       expired;
    } aab_tmr_state_type;

    typedef struct packed {
        logic        twelve_bit_mode_en;
        logic        accumulate_en;
        logic [2:0]  shift_justify_sel;
        logic [2:0]  repeat_count;
        logic        low_power_mode_en;
        logic [3:0]  powerup_time;
        logic [15:0] acc;
        aab_seq_type seq;
        logic [5:0]  conv_left;
        logic        first_conv;
        logic        sar_start;
        logic        done_set;
        logic        power_on;
        logic [7:0]  rdata;
    } aab_state_type;
endpackage

// ---- rtl/aab_pwr_timer.sv ----
// power-up delay timer counting whole 400 ns units
`timescale 1ns/1ps
module aab_pwr_timer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [3:0] units,
    output logic            expired
);
    import aab_pkg::*;

    aab_tmr_state_type s_q;
    aab_tmr_state_type s_d;

    // prescaler divides the fixed clock to one unit; field value plus one units
    always_comb begin
        s_d = s_q;
        s_d.expired = 1'b0;
        if (start) begin
            s_d.busy = 1'b1;
            s_d.prescale = PWR_RELOAD; // RULE20
            s_d.units_left = units; // RULE15
        end else if (s_q.busy) begin
            if (s_q.prescale != 4'h0) begin
                s_d.prescale = s_q.prescale - 4'h1;
            end else if (s_q.units_left == 4'h0) begin
                s_d.busy = 1'b0;
                s_d.expired = 1'b1;
            end else begin
                s_d.units_left = s_q.units_left - 4'h1;
                s_d.prescale = PWR_RELOAD;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign expired = s_q.expired;
endmodule // aab_pwr_timer

// ---- rtl/aab_result_fmt.sv ----
// read-back formatter for the 16-bit accumulator
`timescale 1ns/1ps
module aab_result_fmt (
    input  wire logic [15:0] acc,
    input  wire logic [2:0]  sel,
    input  wire logic        twelve,
    output logic [15:0]      fmt
);
    import aab_pkg::*;

    // right shifts fill with zeros; left justify moves the sample to the top
    always_comb begin
        if (sel < SJ_LEFT) begin
            fmt = acc >> sel; // RULE6
        end else if (sel == SJ_LEFT) begin
            fmt = acc << (twelve ? LEFT_SHIFT_12 : LEFT_SHIFT_10); // RULE7
        end else begin
            fmt = acc; // reserved codes: plain view
        end
    end
endmodule // aab_result_fmt

// ---- bench/adc_accumulator_burst_power_test.sv ----
// self-checking bench of the accumulator, burst and power-up control
`timescale 1ns/1ps
module adc_accumulator_burst_power_test;
    import aab_pkg::*;
    logic            clk;
    logic            rst;
    aab_sfr_req_type sfr;
    logic [7:0]      sfr_rdata;
    logic            burst_mode_en;
    logic            converter_en;
    logic            soc;
    aab_sar_res_type sar;
    logic            sar_start;
    logic            first_conv;
    logic            conversion_done_set;
    logic            converter_power_on;
    logic            twelve_bit_mode_en;
    logic            low_power_mode_en;
    int              n_mismatch;
    int              num_checks;
    logic [31:0]     seed;
    logic [15:0]     model_acc;
    logic [15:0]     v;
    logic [7:0]      b;

    aab_ctrl i_aab_ctrl (
        .clk(clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .burst_mode_en(burst_mode_en), .converter_en(converter_en), .soc(soc), .sar(sar),
        .sar_start(sar_start), .first_conv(first_conv),
        .conversion_done_set(conversion_done_set), .converter_power_on(converter_power_on),
        .twelve_bit_mode_en(twelve_bit_mode_en), .low_power_mode_en(low_power_mode_en)
    );

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // xorshift source, fixed start so every run repeats
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected read-back of the accumulator for a justify code
    function automatic logic [15:0] fmt_exp(input logic [15:0] a, input logic [2:0] s,
                                            input logic tw);
        case (s)
            3'h0, 3'h1, 3'h2, 3'h3: return a >> s;
            3'h4: return tw ? (a << 4) : (a << 6);
            default: return a; // reserved codes show the raw value
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one idle cycle after each access so a strobe never toggles twice in a step
    task automatic sfr_write(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
        sfr.page = pg;
        sfr.addr = ad;
        sfr.wdata = d;
        sfr.wr = 1'b1;
        @(posedge clk); #1;
        sfr.wr = 1'b0;
        @(posedge clk); #1;
    endtask

    task automatic sfr_read(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] d);
        sfr.page = pg;
        sfr.addr = ad;
        sfr.rd = 1'b1;
        @(posedge clk); #1;
        sfr.rd = 1'b0;
        d = sfr_rdata;
        @(posedge clk); #1;
    endtask

    task automatic reg_check(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] e);
        sfr_read(pg, ad, b);
        check(16'(b), 16'(e));
    endtask

    task automatic read_acc(output logic [15:0] r);
        sfr_read(PAGE_MAIN, RES_HI_ADDR, r[15:8]);
        sfr_read(PAGE_MAIN, RES_LO_ADDR, r[7:0]);
    endtask

    // one start; the bench stands in for the converter core and answers each request
    task automatic convert(input int n_conv, input logic [3:0] pwr, input logic accum,
                           input logic tw);
        int          n;
        int          exp_n;
        logic [11:0] d;
        logic [15:0] smp;
        exp_n = (burst_mode_en && !converter_en) ? (int'(pwr) + 1) * 10 + 2 : 1;
        soc = 1'b1;
        @(posedge clk); #1;
        soc = 1'b0;
        for (int k = 0; k < n_conv; k++) begin
            n = 1;
            while (sar_start !== 1'b1 && n < 400) begin
                @(posedge clk); #1;
                n++;
            end
            if (n >= 400) begin
                n_mismatch++;
                conclude();
            end
            if (k == 0) check(16'(n), 16'(exp_n));
            if (k == 0) check(16'(converter_power_on), 16'h0001);
            if (burst_mode_en) check(16'(first_conv), 16'(k == 0));
            d = 12'(rnd());
            repeat (1 + rnd() % 3) @(posedge clk);
            #1;
            sar.data = d;
            sar.done = 1'b1;
            @(posedge clk); #1;
            sar.done = 1'b0;
            sar.data = ~d;
            smp = tw ? 16'(d) : 16'(d[9:0]);
            if ((burst_mode_en && k == 0) || (!burst_mode_en && !accum)) model_acc = smp;
            else model_acc = model_acc + smp;
            check(16'(conversion_done_set), 16'(k == n_conv - 1));
        end
        check(16'(converter_power_on), 16'(converter_en));
        @(posedge clk); #1;
        read_acc(v);
        check(v, model_acc);
    endtask

    // main sequence
    initial begin
        int cnt;
        logic [2:0] r;
        n_mismatch = 0;
        num_checks = 0;
        seed = 32'h9740;
        rst = 1'b1;
        sfr = '0;
        sar = '0;
        soc = 1'b0;
        burst_mode_en = 1'b0;
        converter_en = 1'b0;
        model_acc = 16'h0000;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        reg_check(PAGE_MAIN, ACC_CFG_ADDR, ACC_CFG_RESET);
        reg_check(PAGE_CFG, PWR_CFG_ADDR, PWR_CFG_RESET);
        reg_check(PAGE_MAIN, RES_HI_ADDR, 8'h00);
        reg_check(PAGE_CFG, RES_HI_ADDR, 8'h00);
        $display("test reset done");
        sfr_write(PAGE_MAIN, ACC_CFG_ADDR, 8'hF8);
        reg_check(PAGE_MAIN, ACC_CFG_ADDR, 8'hB8);
        check(16'(twelve_bit_mode_en), 16'h0001);
        sfr_write(PAGE_CFG, PWR_CFG_ADDR, 8'hFF);
        reg_check(PAGE_CFG, PWR_CFG_ADDR, 8'h8F);
        check(16'(low_power_mode_en), 16'h0001);
        sfr_write(PAGE_CFG, PWR_CFG_ADDR, 8'h70);
        check(16'(low_power_mode_en), 16'h0000);
        sfr_write(PAGE_CFG, 8'h00, 8'hFF);
        reg_check(PAGE_CFG, PWR_CFG_ADDR, 8'h00);
        $display("test registers done");
        // every justify code in both resolutions, random accumulator contents
        for (int i = 0; i < 16; i++) begin
            v = 16'(rnd());
            sfr_write(PAGE_MAIN, ACC_CFG_ADDR, {i[3], 1'b0, i[2:0], 3'h0});
            sfr_write(PAGE_MAIN, RES_HI_ADDR, v[15:8]);
            sfr_write(PAGE_MAIN, RES_LO_ADDR, v[7:0]);
            read_acc(model_acc);
            check(model_acc, fmt_exp(v, i[2:0], i[3]));
        end
        $display("test format done");
        converter_en = 1'b1;
        sfr_write(PAGE_MAIN, ACC_CFG_ADDR, 8'h80); // repeat count kept zero
        for (int i = 0; i < 3; i++) convert(1, 4'h0, 1'b0, 1'b1);
        sfr_write(PAGE_MAIN, ACC_CFG_ADDR, 8'hC0);
        sfr_write(PAGE_MAIN, RES_HI_ADDR, 8'h00);
        sfr_write(PAGE_MAIN, RES_LO_ADDR, 8'h00);
        model_acc = 16'h0000;
        for (int i = 0; i < 4; i++) convert(1, 4'h0, 1'b1, 1'b1);
        sfr_write(PAGE_MAIN, ACC_CFG_ADDR, 8'h40);
        convert(1, 4'h0, 1'b1, 1'b0);
        $display("test single done");
        // neither enable: a start must be ignored and the converter stay off
        converter_en = 1'b0;
        soc = 1'b1;
        @(posedge clk); #1;
        soc = 1'b0;
        cnt = 0;
        repeat (30) begin
            @(posedge clk); #1;
            cnt += int'(sar_start);
        end
        check(16'(cnt), 16'h0000);
        check(16'(converter_power_on), 16'h0000);
        $display("test refuse done");
        // warm bursts over all repeat codes, reserved ones act as 64
        converter_en = 1'b1;
        burst_mode_en = 1'b1;
        for (int c = 0; c < 8; c++) begin
            sfr_write(PAGE_MAIN, ACC_CFG_ADDR, {5'h10, c[2:0]});
            reg_check(PAGE_MAIN, ACC_CFG_ADDR, {5'h10, c[2:0]});
            convert(c == 0 ? 1 : (c > 5 ? 64 : 2 << c), 4'h0, 1'b0, 1'b1);
        end
        $display("test warm burst done");
        // cold bursts: boundary and recommended power-up fields, then random
        converter_en = 1'b0;
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 16'h0 : (i == 1) ? 16'h4 : (i == 2) ? 16'hF : 16'(rnd() % 16);
            r = 3'(rnd() % 3);
            sfr_write(PAGE_CFG, PWR_CFG_ADDR, {4'h0, v[3:0]});
            sfr_write(PAGE_MAIN, ACC_CFG_ADDR, {5'h10, r});
            convert(r == 0 ? 1 : 2 << r, v[3:0], 1'b0, 1'b1);
        end
        $display("test cold burst done");
        conclude();
    end
endmodule // adc_accumulator_burst_power_test
